// ### design/tscs_top.sv
// What this block does
// [R1] Config bit 7 masks all alert interrupts
// [R2] Config bit 6 stops conversion, enters standby
// [R3] Config bit 5 sets thermostat alert polarity
// [R4] Config bit 4 selects thermostat mode
// [R5] Config bit 3 drives bias current select
// [R6] Status bit 7 shows conversion busy
// [R7] Status bits 6,5,1,0 read zero
// [R8] Status bit 4 high alarm, thermostat shows the unmasked thermostat state
// [R9] Status bit 3 low alarm, zero in thermostat
// [R10] Status bit 2 flags remote diode fault
// [R11] Normal mode alarm flags stick until read
// [R12] Decode nine addresses from two three-level straps
// [R13] Straps sampled at reset only, then held
// [R14] Also answer the alert response address while the alert latch is held
// [R15] Reset clears the alert interrupt latch
// [R16] Reset loads command pointer with 01h
// [R17] Reset loads high limit max, low C9h
// [R18] Reset leaves latched-interrupt normal mode
// [R19] Alert response read clears latch, returns address
// [R20] Status read clears flags, not the latch
// [R21] Low three config bits forced zero
// [R22] Thermostat alert sets above high limit, holds below low limit, clears in between
`timescale 1ns/1ns
module tscs_top
  import tscs_pkg::*;
#(
  // arbitrary identity values
  parameter logic [7:0] MFG_CODE = 8'h5a,
  parameter logic [7:0] DEV_CODE = 8'ha5
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // address straps, three-level pad codes
  input wire logic [1:0] addr_strap_a,
  input wire logic [1:0] addr_strap_b,
  // register access from the serial front end
  input wire logic acc_cmd_wr,
  input wire logic acc_data_wr,
  input wire logic acc_rd,
  input wire logic acc_ara_rd,
  input wire logic [7:0] acc_wdata,
  input wire logic [6:0] rx_addr,
  output logic addr_match,
  output logic ara_ack,
  output logic [7:0] acc_rdata,
  output logic acc_rvalid,
  // converter side
  input wire logic conv_busy,
  input wire logic conv_done,
  input wire logic diode_fault,
  input wire logic [7:0] temp_value,
  output logic conv_run,
  output logic oneshot_req,
  output logic bias_current_select,
  // alert pin, open drain or driven in thermostat mode
  output logic alert_out,
  output logic alert_oe_n,
  // latched slave address
  output logic [6:0] slave_addr
);
  tscs_alert_if aif();

  logic [1:0] strap_a_s1_r;
  logic [1:0] strap_a_s2_r;
  logic [1:0] strap_b_s1_r;
  logic [1:0] strap_b_s2_r;
  logic [2:0] sample_sh_r;
  logic [6:0] addr_r;
  logic [7:0] cmd_r;
  logic [7:0] cfg_r;
  logic [7:0] cfg_nxt;
  logic [7:0] thi_r;
  logic [7:0] tlo_r;
  logic [7:0] temp_r;
  logic high_alarm_flag_r;
  logic high_alarm_flag_nxt;
  logic low_alarm_flag_r;
  logic low_alarm_flag_nxt;
  logic diode_flag_r;
  logic diode_flag_nxt;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic oneshot_r;

  wire logic [7:0] status_byte;
  wire logic [7:0] rd_mux;
  wire logic stat_rd;
  wire logic wr_cfg;
  wire logic wr_thi;
  wire logic wr_tlo;
  wire logic wr_oneshot;
  wire logic over_high;
  wire logic under_low;
  wire logic ara_ok;
  wire logic [2:0] reserved_bits;

  // maps a pad code to its level index; an illegal code is treated as open
  function automatic logic [1:0] strap_index(input logic [1:0] code);
    unique case (code)
      TSCS_STRAP_GND: strap_index = 2'h0;
      TSCS_STRAP_VCC: strap_index = 2'h2;
      default: strap_index = 2'h1;
    endcase
  endfunction

  function automatic logic [6:0] strap_decode(input logic [1:0] a, input logic [1:0] b);
    logic [3:0] idx;
    idx = {strap_index(a), 2'b00} - {2'b00, strap_index(a)} + {2'b00, strap_index(b)};
    unique case (idx)
      4'h0: strap_decode = TSCS_ADDR_0;
      4'h1: strap_decode = TSCS_ADDR_1;
      4'h2: strap_decode = TSCS_ADDR_2;
      4'h3: strap_decode = TSCS_ADDR_3;
      4'h4: strap_decode = TSCS_ADDR_4;
      4'h5: strap_decode = TSCS_ADDR_5;
      4'h6: strap_decode = TSCS_ADDR_6;
      4'h7: strap_decode = TSCS_ADDR_7;
      default: strap_decode = TSCS_ADDR_8;
    endcase
  endfunction

  // two's complement compare
  function automatic logic signed_gt(input logic [7:0] x, input logic [7:0] y);
    signed_gt = $signed(x) > $signed(y);
  endfunction

  // straps come from pads, so they pass two flops first
  always_ff @(posedge core_clk) begin
    strap_a_s1_r <= addr_strap_a;
    strap_a_s2_r <= strap_a_s1_r;
    strap_b_s1_r <= addr_strap_b;
    strap_b_s2_r <= strap_b_s1_r;
  end

  // address is taken while reset holds, after the synchroniser has filled;
  // later strap changes are never looked at, saving the bias current path.
  // a shift of ones rather than a counter, so an unknown power-up value drains out
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sample_sh_r <= {sample_sh_r[1:0], 1'b1};
      if (&sample_sh_r) begin
        addr_r <= strap_decode(strap_a_s2_r, strap_b_s2_r); // see [R12] see [R13]
      end
    end else begin
      sample_sh_r <= 3'h0;
    end
  end

  // command decode
  assign stat_rd = acc_rd & (cmd_r == TSCS_CMD_RD_STAT);
  assign wr_cfg = acc_data_wr & (cmd_r == TSCS_CMD_WR_CFG);
  assign wr_thi = acc_data_wr & (cmd_r == TSCS_CMD_WR_THI);
  assign wr_tlo = acc_data_wr & (cmd_r == TSCS_CMD_WR_TLO);
  assign wr_oneshot = acc_cmd_wr & (acc_wdata == TSCS_CMD_ONESHOT);
  assign cfg_nxt = acc_wdata & TSCS_CFG_WMASK; // see [R21]

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cmd_r <= TSCS_CMD_RESET; // see [R16]
      cfg_r <= TSCS_CFG_RESET; // see [R18] see [R5]
      thi_r <= TSCS_THI_RESET; // see [R17]
      tlo_r <= TSCS_TLO_RESET; // see [R17]
    end else begin
      if (acc_cmd_wr) begin
        cmd_r <= acc_wdata;
      end
      if (wr_cfg) begin
        cfg_r <= cfg_nxt;
      end
      if (wr_thi) begin
        thi_r <= acc_wdata;
      end
      if (wr_tlo) begin
        tlo_r <= acc_wdata;
      end
    end
  end

  // one-shot is dropped while a conversion runs
  always_ff @(posedge core_clk) begin
    if (reset) begin
      oneshot_r <= 1'b0;
    end else begin
      oneshot_r <= wr_oneshot & ~conv_busy;
    end
  end

  // latest temperature
  always_ff @(posedge core_clk) begin
    if (reset) begin
      temp_r <= 8'h00;
    end else if (conv_done) begin
      temp_r <= temp_value;
    end
  end

  assign over_high = signed_gt(temp_value, thi_r);
  assign under_low = signed_gt(tlo_r, temp_value);

  // flags: a new alarm in the same cycle as a status read survives
  assign high_alarm_flag_nxt = (conv_done & over_high) | (high_alarm_flag_r & ~stat_rd); // see [R8] see [R11] see [R20]
  assign low_alarm_flag_nxt = (conv_done & under_low) | (low_alarm_flag_r & ~stat_rd); // see [R9] see [R11] see [R20]
  assign diode_flag_nxt = (conv_done & diode_fault) | (diode_flag_r & ~stat_rd); // see [R10] see [R20]

  always_ff @(posedge core_clk) begin
    if (reset) begin
      high_alarm_flag_r <= 1'b0;
      low_alarm_flag_r <= 1'b0;
      diode_flag_r <= 1'b0;
    end else begin
      high_alarm_flag_r <= high_alarm_flag_nxt;
      low_alarm_flag_r <= low_alarm_flag_nxt;
      diode_flag_r <= diode_flag_nxt;
    end
  end

  // alert sub-block
  assign aif.mask = cfg_r[TSCS_CFG_MASK];
  assign aif.thermostat_enable_en = cfg_r[TSCS_CFG_THERMOSTAT_ENABLE];
  assign aif.polarity = cfg_r[TSCS_CFG_POL];
  assign aif.conv_done = conv_done;
  assign aif.over_high = over_high;
  assign aif.under_low = under_low;
  assign aif.fault = diode_fault;
  assign aif.ara_clear = ara_ok;

  tscs_alert u_alert (
    .core_clk(core_clk),
    .reset(reset),
    .aif(aif)
  );

  assign reserved_bits = 3'h0;
  assign status_byte = {
    conv_busy, // see [R6]
    reserved_bits[1:0], // see [R7]
    aif.thermostat_enable_en ? aif.thermostat_enable_state : high_alarm_flag_r, // see [R8]
    aif.thermostat_enable_en ? 1'b0 : low_alarm_flag_r, // see [R9]
    diode_flag_r,
    reserved_bits[1:0] // see [R7]
  };

  // read data selection
  assign rd_mux = (cmd_r == TSCS_CMD_RD_TEMP) ? temp_r :
                  (cmd_r == TSCS_CMD_RD_STAT) ? status_byte :
                  (cmd_r == TSCS_CMD_RD_CFG) ? cfg_r :
                  (cmd_r == TSCS_CMD_RD_RATE) ? TSCS_RATE_VALUE :
                  (cmd_r == TSCS_CMD_RD_THI) ? thi_r :
                  (cmd_r == TSCS_CMD_RD_TLO) ? tlo_r :
                  (cmd_r == TSCS_CMD_RD_MFG) ? MFG_CODE :
                  (cmd_r == TSCS_CMD_RD_DEV) ? DEV_CODE : 8'h00;

  // only a device holding its latch takes part in the alert response
  assign ara_ok = acc_ara_rd & aif.latch; // see [R19]

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= acc_rd | ara_ok;
      if (ara_ok) begin
        rdata_r <= {addr_r, 1'b1}; // see [R19]
      end else if (acc_rd) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign addr_match = (rx_addr == addr_r) | ((rx_addr == TSCS_ARA_ADDR) & aif.latch); // see [R14]
  assign ara_ack = aif.latch;
  assign acc_rdata = rdata_r;
  assign acc_rvalid = rvalid_r;
  assign slave_addr = addr_r;
  assign conv_run = ~cfg_r[TSCS_CFG_STBY]; // see [R2]
  assign oneshot_req = oneshot_r;
  assign bias_current_select = cfg_r[TSCS_CFG_BIAS]; // see [R5]
  // normal mode is open drain active low; thermostat mode drives the chosen level
  assign alert_out = aif.thermostat_enable_en ? ~(aif.alert_active ^ aif.polarity) : 1'b0; // see [R3]
  assign alert_oe_n = aif.thermostat_enable_en ? 1'b0 : ~aif.alert_active;
endmodule

// ### design/tscs_pkg.sv
package tscs_pkg;
  // strap level codes as reported by the three-level pad detector
  typedef enum logic [1:0] {
    TSCS_STRAP_GND  = 2'b00,
    TSCS_STRAP_OPEN = 2'b01,
    TSCS_STRAP_VCC  = 2'b10
  } tscs_strap_e;

  // command codes
  localparam logic [7:0] TSCS_CMD_RD_TEMP = 8'h01;
  localparam logic [7:0] TSCS_CMD_RD_STAT = 8'h02;
  localparam logic [7:0] TSCS_CMD_RD_CFG = 8'h03;
  localparam logic [7:0] TSCS_CMD_RD_RATE = 8'h04;
  localparam logic [7:0] TSCS_CMD_RD_THI = 8'h07;
  localparam logic [7:0] TSCS_CMD_RD_TLO = 8'h08;
  localparam logic [7:0] TSCS_CMD_WR_CFG = 8'h09;
  localparam logic [7:0] TSCS_CMD_WR_THI = 8'h0d;
  localparam logic [7:0] TSCS_CMD_WR_TLO = 8'h0e;
  localparam logic [7:0] TSCS_CMD_ONESHOT = 8'h0f;
  localparam logic [7:0] TSCS_CMD_RD_MFG = 8'hfe;
  localparam logic [7:0] TSCS_CMD_RD_DEV = 8'hff;

  // reset values
  localparam logic [7:0] TSCS_CMD_RESET = 8'h01;
  localparam logic [7:0] TSCS_CFG_RESET = 8'h08;
  localparam logic [7:0] TSCS_THI_RESET = 8'h7f;
  localparam logic [7:0] TSCS_TLO_RESET = 8'hc9;
  localparam logic [7:0] TSCS_RATE_VALUE = 8'h07;

  // configuration bit positions
  localparam int TSCS_CFG_MASK = 7;
  localparam int TSCS_CFG_STBY = 6;
  localparam int TSCS_CFG_POL = 5;
  localparam int TSCS_CFG_THERMOSTAT_ENABLE = 4;
  localparam int TSCS_CFG_BIAS = 3;
  localparam logic [7:0] TSCS_CFG_WMASK = 8'hf8;

  // status bit positions
  localparam int TSCS_ST_BUSY = 7;
  localparam int TSCS_ST_HIGH = 4;
  localparam int TSCS_ST_LOW = 3;
  localparam int TSCS_ST_DIODE = 2;

  // bus alert response address
  localparam logic [6:0] TSCS_ARA_ADDR = 7'h0c;

  // strapped slave addresses, index is strap_a * 3 + strap_b
  localparam logic [6:0] TSCS_ADDR_0 = 7'b0011000;
  localparam logic [6:0] TSCS_ADDR_1 = 7'b0011001;
  localparam logic [6:0] TSCS_ADDR_2 = 7'b0011010;
  localparam logic [6:0] TSCS_ADDR_3 = 7'b0101001;
  localparam logic [6:0] TSCS_ADDR_4 = 7'b0101010;
  localparam logic [6:0] TSCS_ADDR_5 = 7'b0101011;
  localparam logic [6:0] TSCS_ADDR_6 = 7'b1001100;
  localparam logic [6:0] TSCS_ADDR_7 = 7'b1001101;
  localparam logic [6:0] TSCS_ADDR_8 = 7'b1001110;
endpackage

// ### design/tscs_alert_if.sv
`timescale 1ns/1ns
interface tscs_alert_if;
  logic mask;
  logic thermostat_enable_en;
  logic polarity;
  logic conv_done;
  logic over_high;
  logic under_low;
  logic fault;
  logic ara_clear;
  logic latch;
  logic thermostat_enable_state;
  logic alert_active;

  modport core (
    output mask, thermostat_enable_en, polarity, conv_done, over_high, under_low, fault, ara_clear,
    input latch, thermostat_enable_state, alert_active
  );
  modport alert (
    input mask, thermostat_enable_en, polarity, conv_done, over_high, under_low, fault, ara_clear,
    output latch, thermostat_enable_state, alert_active
  );
endinterface

// ### design/tscs_alert.sv
`timescale 1ns/1ns
module tscs_alert
  import tscs_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // alert control and state
  tscs_alert_if.alert aif
);
  logic latch_r;
  logic latch_nxt;
  logic thermostat_enable_r;
  logic thermostat_enable_nxt;
  wire logic alert_event;

  assign alert_event = aif.conv_done & (aif.over_high | aif.under_low | aif.fault) & ~aif.mask; // see [R1]
  // set wins over the alert response clear
  assign latch_nxt = alert_event ? 1'b1 : (aif.ara_clear ? 1'b0 : latch_r); // see [R19]
  assign thermostat_enable_nxt = !aif.conv_done ? thermostat_enable_r :
                     aif.over_high ? 1'b1 :
                     aif.under_low ? thermostat_enable_r : 1'b0; // see [R22]

  always_ff @(posedge core_clk) begin
    if (reset) begin
      latch_r <= 1'b0; // see [R15]
      thermostat_enable_r <= 1'b0;
    end else begin
      latch_r <= aif.thermostat_enable_en ? 1'b0 : latch_nxt;
      thermostat_enable_r <= aif.thermostat_enable_en ? thermostat_enable_nxt : 1'b0;
    end
  end

  assign aif.latch = latch_r;
  assign aif.thermostat_enable_state = thermostat_enable_r;
  // thermostat output follows the comparator, normal mode follows the latch
  assign aif.alert_active = aif.thermostat_enable_en ? (thermostat_enable_r & ~aif.mask) : latch_r; // see [R4] see [R18]
endmodule

// ### tb/tscs_checker.sv
`timescale 1ns/1ns
module tscs_checker
  import tscs_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // watched ports
  input wire logic acc_cmd_wr,
  input wire logic acc_data_wr,
  input wire logic acc_rd,
  input wire logic acc_ara_rd,
  input wire logic [7:0] acc_wdata,
  input wire logic [6:0] rx_addr,
  input wire logic addr_match,
  input wire logic ara_ack,
  input wire logic [7:0] acc_rdata,
  input wire logic acc_rvalid,
  input wire logic conv_busy,
  input wire logic conv_done,
  input wire logic conv_run,
  input wire logic oneshot_req,
  input wire logic alert_out,
  input wire logic alert_oe_n,
  input wire logic [6:0] slave_addr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  AST_RUN_HOLD: assert property (!$past(acc_data_wr) |-> $stable(conv_run))
    else $error("run changed without a write");
  AST_ONESHOT: assert property (oneshot_req |-> $past(acc_cmd_wr) && !$past(conv_busy)
    && $past(acc_wdata) == TSCS_CMD_ONESHOT) else $error("stray one-shot");
  AST_RD_ANSWER: assert property (acc_rd |=> acc_rvalid) else $error("read not answered");
  AST_ARA_DATA: assert property (acc_ara_rd && ara_ack && !acc_rd |=>
    acc_rvalid && acc_rdata == {slave_addr, 1'b1}) else $error("bad alert response");
  AST_ARA_REFUSE: assert property (acc_ara_rd && !ara_ack && !acc_rd |=> !acc_rvalid)
    else $error("alert response without latch");
  AST_ADDR_HOLD: assert property ($stable(slave_addr)) else $error("address moved");
  AST_MATCH: assert property (rx_addr == slave_addr |-> addr_match) else $error("no match");
  AST_ARA_MATCH: assert property (rx_addr == TSCS_ARA_ADDR && ara_ack |-> addr_match)
    else $error("alert address ignored");
  AST_PIN_LOW: assert property (ara_ack |-> !alert_oe_n && !alert_out) else $error("pin idle");
  AST_LATCH_SET: assert property ($rose(ara_ack) |-> $past(conv_done)) else $error("latch set");
  cover property (acc_ara_rd && ara_ack);
  cover property (oneshot_req);
  cover property (!alert_oe_n && !ara_ack);
endmodule
bind tscs_top tscs_checker u_tscs_checker (.*);

// ### tb/tscs_conv_model.sv
`timescale 1ns/1ns
module tscs_conv_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // start requests and result
  input wire logic oneshot_req,
  input wire logic go,
  input wire logic [7:0] t_in,
  input wire logic f_in,
  // converter outputs
  output logic conv_busy,
  output logic conv_done,
  output logic diode_fault,
  output logic [7:0] temp_value
);
  logic [2:0] cnt_r;
  // results are only valid with done, so they toggle in between
  always_ff @(posedge core_clk) begin
    conv_done <= 1'b0;
    temp_value <= ~temp_value;
    diode_fault <= ~diode_fault;
    if (reset) begin
      conv_busy <= 1'b0;
      cnt_r <= 3'h0;
      temp_value <= 8'h5a;
      diode_fault <= 1'b0;
    end else if (!conv_busy && (go || oneshot_req)) begin
      conv_busy <= 1'b1;
      cnt_r <= 3'h5;
    end else if (conv_busy) begin
      cnt_r <= cnt_r - 3'h1;
      if (cnt_r == 3'h0) begin
        conv_busy <= 1'b0;
        conv_done <= 1'b1;
        temp_value <= t_in;
        diode_fault <= f_in;
      end
    end
  end
endmodule

// ### tb/temp_sensor_config_status_tb_top.sv
`timescale 1ns/1ns
module temp_sensor_config_status_tb_top;
  import tscs_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] addr_strap_a = 2'b01;
  logic [1:0] addr_strap_b = 2'b01;
  logic acc_cmd_wr = 1'b0;
  logic acc_data_wr = 1'b0;
  logic acc_rd = 1'b0;
  logic acc_ara_rd = 1'b0;
  logic [7:0] acc_wdata = 8'h00;
  logic [6:0] rx_addr = 7'h00;
  logic go = 1'b0;
  logic [7:0] t_in = 8'h00;
  logic f_in = 1'b0;
  logic addr_match, ara_ack, acc_rvalid, conv_busy, conv_done, diode_fault, conv_run, oneshot_req;
  logic bias_current_select, alert_out, alert_oe_n;
  logic [7:0] acc_rdata, temp_value;
  logic [6:0] slave_addr;
  int mismatches = 0;
  int cmp_count = 0;
  logic [6:0] adr [9] = '{7'h18, 7'h19, 7'h1a, 7'h29, 7'h2a, 7'h2b, 7'h4c, 7'h4d, 7'h4e};
  always #4 core_clk = ~core_clk;
  tscs_top u_tscs_top (.*);
  tscs_conv_model u_tscs_conv_model (.*);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic strobe(ref logic s, input logic [7:0] d);
    s = 1'b1;
    acc_wdata = d;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic put(input logic [7:0] cmd, input logic [7:0] d);
    strobe(acc_cmd_wr, cmd);
    strobe(acc_data_wr, d);
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
    strobe(acc_cmd_wr, cmd);
    strobe(acc_rd, 8'h00);
    chk({8{acc_rvalid}} & acc_rdata, exp);
  endtask
  task automatic ara(input logic [7:0] exp);
    strobe(acc_ara_rd, 8'h00);
    chk({8{acc_rvalid}} & acc_rdata, exp);
  endtask
  task automatic conv(input logic [7:0] t, input logic f);
    t_in = t;
    f_in = f;
    strobe(go, 8'h00);
    for (int i = 0; i < 40; i++) begin
      cyc(1);
      if (conv_done === 1'b1) begin
        cyc(1);
        return;
      end
    end
    mismatches++;
    summarize();
  endtask
  initial begin
    logic [7:0] v, h, l, t;
    logic a;
    void'($urandom(43450));
    for (int i = 0; i < 10; i++) begin
      reset = 1'b1;
      addr_strap_a = (i < 9) ? 2'(i / 3) : 2'b01;
      addr_strap_b = (i < 9) ? 2'(i % 3) : 2'b01;
      cyc(6);
      reset = 1'b0;
      addr_strap_a = 2'($urandom_range(2));
      cyc(2);
      rx_addr = adr[(i < 9) ? i : 4];
      cyc(1);
      chk({addr_match, slave_addr}, {1'b1, adr[(i < 9) ? i : 4]});
    end
    chk({6'h0, bias_current_select, alert_oe_n}, 8'h03);
    t = 8'($urandom_range(60));
    conv(t, 1'b0);
    strobe(acc_rd, 8'h00);
    chk(acc_rdata, t);
    rd(8'h03, 8'h08);
    rd(8'h07, 8'h7f);
    rd(8'h08, 8'hc9);
    rd(8'h02, 8'h00);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'hff : 8'($urandom);
      put(8'h09, v);
      chk({6'h0, conv_run, bias_current_select}, {6'h0, ~v[6], v[3]});
      rd(8'h03, v & 8'hf8);
    end
    h = 8'($urandom_range(60, 10));
    l = 8'hf0 - 8'($urandom_range(20));
    put(8'h0d, h);
    put(8'h0e, l);
    for (int k = 0; k < 4; k++) begin
      put(8'h09, (k == 3) ? 8'h88 : 8'h08);
      conv((k == 1) ? l - 8'h01 : (k == 2) ? 8'h00 : h + 8'h01, k == 2);
      if (k < 2) begin
        conv(8'h00, 1'b0);
      end
      chk({6'h0, ara_ack, alert_oe_n}, (k == 3) ? 8'h01 : 8'h02);
      rd(8'h02, 8'h10 >> (k % 3));
      rd(8'h02, 8'h00);
      rx_addr = 7'h0c;
      cyc(1);
      chk({6'h0, ara_ack, addr_match}, (k == 3) ? 8'h00 : 8'h03);
      ara((k == 3) ? 8'h00 : {7'h2a, 1'b1});
      ara(8'h00);
    end
    for (int p = 0; p < 2; p++) begin
      put(8'h09, p ? 8'h38 : 8'h18);
      for (int k = 0; k < 3; k++) begin
        a = (k < 2);
        conv((k == 0) ? h + 8'h01 : (k == 1) ? l - 8'h01 : 8'h00, 1'b0);
        chk({6'h0, alert_out, alert_oe_n}, {6'h0, a ~^ p[0], 1'b0});
        rd(8'h02, a ? 8'h10 : 8'h00);
      end
    end
    put(8'h09, 8'h08);
    strobe(acc_cmd_wr, 8'h0f);
    cyc(2);
    rd(8'h02, 8'h80);
    cyc(12);
    rd(8'h02, 8'h00);
    summarize();
  end
endmodule
